// ==== core/bcms_pkg.sv ====
package bcms_pkg;
  // Datapath widths
  localparam int ADDR_W      = 24;
  localparam int COUNT_W     = 16;
  localparam int SHORT_W     = 8;
  // Cycle budget: fixed overhead plus per-byte cost
  localparam int OVERHEAD_ST = 8;
  localparam int PER_BYTE_ST = 4;
  // Idle bookkeeping states before and after the loop
  localparam int SETUP_ST    = 4;
  localparam int FINISH_ST   = OVERHEAD_ST - SETUP_ST;
  localparam logic [3:0] STEP_ONE = 4'h1;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    BCMS_IDLE   = 6'h01,
    BCMS_SETUP  = 6'h02,
    BCMS_READ   = 6'h04,
    BCMS_WAIT   = 6'h08,
    BCMS_WRITE  = 6'h10,
    BCMS_FINISH = 6'h20
  } bcms_state_type;
endpackage : bcms_pkg

// ==== core/bcms_bus_if.sv ====
`timescale 1ns/1ps
// Memory bus between sequencer and port stage
interface bcms_bus_if;
  import bcms_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [7:0]        wdata;
  modport seq (output addr, output rd, output wr, output wdata);
  modport port (input addr, input rd, input wr, input wdata);
endinterface : bcms_bus_if

// ==== core/bcms_bus_reg.sv ====
`timescale 1ns/1ps
// Registers the bus requests so every memory output comes from a flip-flop
module bcms_bus_reg
  import bcms_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Request side
  bcms_bus_if.port               req,
  // Memory pins
  output logic [bcms_pkg::ADDR_W-1:0] mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata
);
  import bcms_pkg::*;

  logic [ADDR_W-1:0] next_addr;
  logic              next_rd;
  logic              next_wr;
  logic [7:0]        next_wdata;

  // Next bus values
  always_comb begin
    next_addr  = req.addr;
    next_rd    = req.rd;
    next_wr    = req.wr;
    next_wdata = req.wdata;
  end

  // Bus registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_addr  <= '0;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      mem_addr  <= next_addr;
      mem_rd    <= next_rd;
      mem_wr    <= next_wr;
      mem_wdata <= next_wdata;
    end
  end
endmodule : bcms_bus_reg

// ==== core/bcms_sequencer.sv ====
`timescale 1ns/1ps
module bcms_sequencer
  import bcms_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Instruction start
  input  wire logic                        start,
  input  wire logic                        block_copy_long_count,
  input  wire logic [bcms_pkg::COUNT_W-1:0] count_word_in,
  input  wire logic [bcms_pkg::ADDR_W-1:0]  source_pointer_in,
  input  wire logic [bcms_pkg::ADDR_W-1:0]  dest_pointer_in,
  // Memory read data, valid in the same cycle as the mem_rd strobe
  input  wire logic [7:0]                  mem_rdata,
  // Memory bus
  output logic [bcms_pkg::ADDR_W-1:0]       mem_addr,
  output logic                             mem_rd,
  output logic                             mem_wr,
  output logic [7:0]                       mem_wdata,
  // Register results and status
  output logic [bcms_pkg::COUNT_W-1:0]      count_word_reg,
  output logic [bcms_pkg::ADDR_W-1:0]       source_pointer_reg,
  output logic [bcms_pkg::ADDR_W-1:0]       dest_pointer_reg,
  output logic                             busy,
  output logic                             done
);
  import bcms_pkg::*;

  // Request bus towards the registered port stage
  bcms_bus_if bus ();

  // Control state
  bcms_state_type     state;
  bcms_state_type     next_state;
  logic               long_mode;
  logic               next_long_mode;
  logic [3:0]         phase;
  logic [3:0]         next_phase;
  logic               next_busy;
  logic               next_done;
  // Decisions handed from control to the datapath
  logic               load_operands;
  logic               step_byte;
  logic               capture_data;
  // Datapath state
  logic [7:0]         data;
  logic [7:0]         next_data;
  logic [COUNT_W-1:0] next_count;
  logic [ADDR_W-1:0]  next_src;
  logic [ADDR_W-1:0]  next_dst;
  logic [COUNT_W-1:0] stepped_count;

  // Count still to move under the active form
  function automatic logic count_left(input logic lm, input logic [COUNT_W-1:0] c);
    count_left = lm ? (c != COUNT_ZERO) : (c[SHORT_W-1:0] != COUNT_ZERO[SHORT_W-1:0]);
  endfunction : count_left

  // Count after one byte; the short form never touches the high byte
  function automatic logic [COUNT_W-1:0] count_step(input logic lm, input logic [COUNT_W-1:0] c);
    if (lm) begin
      count_step = c - COUNT_W'(1);
    end else begin
      count_step = {c[COUNT_W-1:SHORT_W], c[SHORT_W-1:0] - SHORT_W'(1)};
    end
  endfunction : count_step

  // Count as it will stand once the current byte is done
  assign stepped_count = count_step(long_mode, count_word_reg);

  // Sequencer next-state logic
  always_comb begin
    next_state     = state;
    next_long_mode = long_mode;
    next_phase     = phase;
    next_busy      = busy;
    next_done      = 1'b0;
    load_operands  = 1'b0;
    step_byte      = 1'b0;
    capture_data   = 1'b0;
    case (state)
      BCMS_IDLE: begin
        if (start) begin
          next_state     = BCMS_SETUP;
          next_long_mode = block_copy_long_count;
          next_phase     = STEP_ONE;
          next_busy      = 1'b1;
          load_operands  = 1'b1;
        end
      end
      BCMS_SETUP: begin
        next_phase = phase + STEP_ONE;
        if (phase == 4'(SETUP_ST - 1)) begin
          next_phase = STEP_ONE;
          next_state = count_left(long_mode, count_word_reg) ? BCMS_READ : BCMS_FINISH;
        end
      end
      BCMS_READ: begin
        next_state = BCMS_WAIT;
      end
      BCMS_WAIT: begin
        capture_data = 1'b1;
        next_state   = BCMS_WRITE;
        next_phase   = STEP_ONE;
      end
      BCMS_WRITE: begin
        // Two write states keep each byte at four states
        next_phase = phase + STEP_ONE;
        if (phase != STEP_ONE) begin
          step_byte  = 1'b1;
          next_phase = STEP_ONE;
          next_state = count_left(long_mode, stepped_count) ? BCMS_READ : BCMS_FINISH;
        end
      end
      BCMS_FINISH: begin
        next_phase = phase + STEP_ONE;
        if (phase == 4'(FINISH_ST)) begin
          next_state = BCMS_IDLE;
          next_busy  = 1'b0;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = BCMS_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  // Register file next values: load at start, step after each byte
  always_comb begin
    next_count = count_word_reg;
    next_src   = source_pointer_reg;
    next_dst   = dest_pointer_reg;
    next_data  = data;
    if (load_operands) begin
      next_count = count_word_in;
      next_src   = source_pointer_in;
      next_dst   = dest_pointer_in;
    end
    if (step_byte) begin
      next_count = stepped_count;
      next_src   = source_pointer_reg + ADDR_W'(1);
      next_dst   = dest_pointer_reg + ADDR_W'(1);
    end
    if (capture_data) begin
      next_data = mem_rdata;
    end
  end

  // Bus requests: read from the source, write to the destination
  always_comb begin
    bus.addr  = source_pointer_reg;
    bus.rd    = 1'b0;
    bus.wr    = 1'b0;
    bus.wdata = data;
    case (state)
      BCMS_READ: begin
        bus.rd = 1'b1;
      end
      BCMS_WRITE: begin
        bus.addr = dest_pointer_reg;
        bus.wr   = (phase == STEP_ONE);
      end
      default: begin
        bus.rd = 1'b0;
      end
    endcase
  end

  // Control registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state     <= BCMS_IDLE;
      long_mode <= 1'b0;
      phase     <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else begin
      state     <= next_state;
      long_mode <= next_long_mode;
      phase     <= next_phase;
      busy      <= next_busy;
      done      <= next_done;
    end
  end

  // Register file and data registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data               <= 8'h00;
      count_word_reg     <= COUNT_ZERO;
      source_pointer_reg <= '0;
      dest_pointer_reg   <= '0;
    end else begin
      data               <= next_data;
      count_word_reg     <= next_count;
      source_pointer_reg <= next_src;
      dest_pointer_reg   <= next_dst;
    end
  end

  // Registered memory port
  bcms_bus_reg u_bus_reg (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .req       (bus.port),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_wdata (mem_wdata)
  );
endmodule : bcms_sequencer

// ==== tb/bcms_seq_monitor.sv ====
`timescale 1ns/1ps
module bcms_seq_monitor
  import bcms_pkg::*;
(
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         sys_rst,
  // Instruction start
  input wire logic                         start,
  input wire logic                         block_copy_long_count,
  input wire logic [bcms_pkg::COUNT_W-1:0] count_word_in,
  input wire logic [bcms_pkg::ADDR_W-1:0]  source_pointer_in,
  input wire logic [bcms_pkg::ADDR_W-1:0]  dest_pointer_in,
  // Memory bus
  input wire logic [7:0]                   mem_rdata,
  input wire logic [bcms_pkg::ADDR_W-1:0]  mem_addr,
  input wire logic                         mem_rd,
  input wire logic                         mem_wr,
  input wire logic [7:0]                   mem_wdata,
  // Register results and status
  input wire logic [bcms_pkg::COUNT_W-1:0] count_word_reg,
  input wire logic [bcms_pkg::ADDR_W-1:0]  source_pointer_reg,
  input wire logic [bcms_pkg::ADDR_W-1:0]  dest_pointer_reg,
  input wire logic                         busy,
  input wire logic                         done
);
  import bcms_pkg::*;
  logic [19:0] cyc;
  logic [15:0] n, ce;
  logic [23:0] s0, d0, ra;
  logic [7:0] rb;
  // Latch operands at an accepted start, count states, keep the last read
  always_ff @(posedge ref_clk) begin
    cyc <= cyc + 20'h1;
    if (mem_rd) begin
      ra <= mem_addr;
      rb <= mem_rdata;
    end
    if (start && !busy && !sys_rst) begin
      cyc <= 20'h1; // The start edge counts as the first state
      n <= block_copy_long_count ? count_word_in : {8'h00, count_word_in[7:0]};
      ce <= block_copy_long_count ? 16'h0000 : {count_word_in[15:8], 8'h00};
      s0 <= source_pointer_in;
      d0 <= dest_pointer_in;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_start_busy: assert property (start && !busy |=> busy) else $error("start not taken");
  chk_done_time: assert property (done |-> cyc == 20'(OVERHEAD_ST + PER_BYTE_ST * n)) else $error("bad length");
  chk_end_count: assert property (done |-> count_word_reg == ce) else $error("bad end count");
  chk_end_src: assert property (done |-> source_pointer_reg == s0 + 24'(n)) else $error("bad end src");
  chk_end_dst: assert property (done |-> dest_pointer_reg == d0 + 24'(n)) else $error("bad end dst");
  chk_zero_idle: assert property (busy && n == 16'h0 |-> !mem_rd && !mem_wr) else $error("zero count moved");
  chk_wr_addr: assert property (mem_wr |-> mem_addr == d0 + (ra - s0)) else $error("bad write addr");
  chk_wr_data: assert property (mem_wr |-> mem_wdata == rb && $past(mem_rd, 2)) else $error("bad write data");
endmodule : bcms_seq_monitor
bind bcms_sequencer bcms_seq_monitor mon (
  .ref_clk               (ref_clk),
  .sys_rst               (sys_rst),
  .start                 (start),
  .block_copy_long_count (block_copy_long_count),
  .count_word_in         (count_word_in),
  .source_pointer_in     (source_pointer_in),
  .dest_pointer_in       (dest_pointer_in),
  .mem_rdata             (mem_rdata),
  .mem_addr              (mem_addr),
  .mem_rd                (mem_rd),
  .mem_wr                (mem_wr),
  .mem_wdata             (mem_wdata),
  .count_word_reg        (count_word_reg),
  .source_pointer_reg    (source_pointer_reg),
  .dest_pointer_reg      (dest_pointer_reg),
  .busy                  (busy),
  .done                  (done)
);

// ==== tb/bcms_mem_model.sv ====
`timescale 1ns/1ps
// Byte memory on the registered memory pins, answering a read in the strobe cycle
module bcms_mem_model
  import bcms_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  output logic      [7:0]        mem_rdata
);
  logic [7:0] junk = 8'h3C;
  // Undriven cycles show a value that changes every cycle
  always @(posedge ref_clk) junk <= ~junk;
  // Contents are a fixed function of the address
  assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5A) : junk;
endmodule : bcms_mem_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import bcms_pkg::*;
  logic ref_clk, sys_rst, start, block_copy_long_count, mem_rd, mem_wr, busy, done;
  logic [COUNT_W-1:0] count_word_in, count_word_reg;
  logic [ADDR_W-1:0] source_pointer_in, dest_pointer_in, mem_addr, source_pointer_reg, dest_pointer_reg;
  logic [7:0] mem_rdata, mem_wdata;
  integer seed = 32'hFE043AB9;
  int err_count, checks;
  logic [31:0] wq[$];
  logic [63:0] dq[$];
  bcms_sequencer dut (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .start                 (start),
    .block_copy_long_count (block_copy_long_count),
    .count_word_in         (count_word_in),
    .source_pointer_in     (source_pointer_in),
    .dest_pointer_in       (dest_pointer_in),
    .mem_rdata             (mem_rdata),
    .mem_addr              (mem_addr),
    .mem_rd                (mem_rd),
    .mem_wr                (mem_wr),
    .mem_wdata             (mem_wdata),
    .count_word_reg        (count_word_reg),
    .source_pointer_reg    (source_pointer_reg),
    .dest_pointer_reg      (dest_pointer_reg),
    .busy                  (busy),
    .done                  (done)
  );
  bcms_mem_model mem (
    .ref_clk   (ref_clk),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_rdata (mem_rdata)
  );
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] pat(logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat
  task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
    checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : cmp
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // Take the oldest note whenever a write or a completion shows, mid-cycle once outputs have settled
  always @(negedge ref_clk) begin
    if (mem_wr === 1'b1) cmp("write", wq.size() ? 64'(wq.pop_front()) : 'x, 64'({mem_addr, mem_wdata}));
    if (done === 1'b1) cmp("done", dq.size() ? dq.pop_front() : 'x, {count_word_reg, source_pointer_reg, dest_pointer_reg});
  end
  // One instruction, optionally with a start that must be ignored
  task automatic run(logic lg, logic [15:0] c, bit bad);
    logic [23:0] s, d;
    int n, k;
    s = 24'($random(seed));
    d = 24'($random(seed));
    n = lg ? c : c[7:0];
    for (k = 0; k < n; k++) wq.push_back({d + 24'(k), pat(s + 24'(k))});
    dq.push_back({lg ? 16'h0000 : {c[15:8], 8'h00}, s + 24'(n), d + 24'(n)});
    {start, block_copy_long_count, count_word_in, source_pointer_in, dest_pointer_in} = {1'b1, lg, c, s, d};
    @(posedge ref_clk) #1 start = 0;
    if (bad) begin
      repeat (2) @(posedge ref_clk);
      #1 {start, count_word_in, source_pointer_in} = {1'b1, ~c, ~s};
      @(posedge ref_clk) #1 start = 0;
    end
    for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge ref_clk) #1;
    if (k == 2000) begin
      err_count++;
      complete_run();
    end
    $display("test end long=%0d count=%h", lg, c);
  endtask : run
  initial begin
    {sys_rst, start, block_copy_long_count, count_word_in, source_pointer_in, dest_pointer_in} = {1'b1, 66'h0};
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 0;
    cmp("reset", 64'h0, 64'({busy, done, mem_rd, mem_wr, count_word_reg}));
    run(0, 16'h1203, 1);
    run(0, 16'h0300, 0);
    run(1, 16'h0000, 0);
    run(1, 16'h0100, 1);
    for (int i = 0; i < 4; i++) run(1'(i), 16'($random(seed)) & 16'h001F, 0);
    // Let the watcher take the last completion note first
    @(negedge ref_clk) #1;
    cmp("left", 64'h0, 64'(wq.size() + dq.size()));
    complete_run();
  end
endmodule : testbench
